// file: hdl/adc_mux_sequencer_control.v
// Purpose: strobe handshake, mux addressing, scan and sequencer control
// Assumes: all pins but RESULT_I asynchronous, synchronised by two flip-flops
// Notes: the converter result arrives on RESULT_I when a conversion ends
`timescale 1ns/1ns
`include "adc_seq_defines.vh"
`default_nettype none
module adc_mux_sequencer_control #(
	parameter RES_W = `RES_BITS,
	parameter CONV_CYC = `CONV_CYCLES
) (
	input wire CLK_I,
	input wire RST_I,
	input wire CS_N_I,
	input wire RD_N_I,
	input wire WR_N_I,
	input wire CONVERSION_START_N_I,
	input wire MODE_SELECT_UPPER_I,
	input wire MODE_SELECT_LOWER_I,
	input wire DIFFERENTIAL_SELECT_I,
	input wire GAIN_RANGE_SELECT_I,
	input wire POLARITY_SELECT_I,
	input wire [2:0] MUX_ADDR_IN_I,
	input wire [RES_W-1:0] RESULT_I,
	input wire RESULT_READY_I,
	output wire BUSY_N_O,
	output wire SAMPLE_O,
	output reg [2:0] MUX_SEL_O,
	output reg MUX_DIFFERENTIAL_SELECT_O,
	output reg GAIN_O,
	output reg POLARITY_O,
	output reg [RES_W-1:0] DATA_O,
	output wire [RES_W-1:0] DATA_OE_O,
	output reg [2:0] MUX_ADDR_OUT_O,
	output reg DIFFERENTIAL_FLAG_OUT_O,
	output wire ADDR_OE_O
);
	localparam CW = 16;
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_CONV = 2'b01;
	localparam [1:0] ST_DONE = 2'b10;
	// two-flop synchronisers for every input pin except RESULT_I, one generate loop
	localparam NS = 15;
	wire [NS-1:0] pin_raw = {CS_N_I, RD_N_I, WR_N_I, CONVERSION_START_N_I,
		MODE_SELECT_UPPER_I, MODE_SELECT_LOWER_I, DIFFERENTIAL_SELECT_I,
		GAIN_RANGE_SELECT_I, POLARITY_SELECT_I, MUX_ADDR_IN_I,
		RESULT_READY_I, 2'b11};
	wire [NS-1:0] pin_s;
	genvar g;
	generate
		for (g = 0; g < NS; g = g + 1) begin : sync
			reg meta_ff;
			reg sync_ff;
			always @(posedge CLK_I) begin
				if (RST_I) begin
					meta_ff <= 1'b1;
					sync_ff <= 1'b1;
				end else begin
					meta_ff <= pin_raw[g];
					sync_ff <= meta_ff;
				end
			end
			assign pin_s[g] = sync_ff;
		end
	endgenerate
	wire cs_n = pin_s[14];
	wire rd_n = pin_s[13];
	wire wr_n = pin_s[12];
	wire cv_n = pin_s[11];
	wire m1 = pin_s[10];
	wire m0 = pin_s[9];
	wire dif = pin_s[8];
	wire gain = pin_s[7];
	wire pol = pin_s[6];
	wire [2:0] ain = pin_s[5:3];
	wire rdy = pin_s[2];
	reg cs_n_ff, rd_n_ff, wr_n_ff, cv_n_ff, m1_ff, m0_ff;
	always @(posedge CLK_I) begin
		if (RST_I) begin
			{cs_n_ff, rd_n_ff, wr_n_ff, cv_n_ff, m1_ff, m0_ff} <= 6'h3f;
		end else begin
			{cs_n_ff, rd_n_ff, wr_n_ff, cv_n_ff, m1_ff, m0_ff} <=
				{cs_n, rd_n, wr_n, cv_n, m1, m0};
		end
	end
	wire wr_rise = wr_n & ~wr_n_ff;
	wire rd_rise = rd_n & ~rd_n_ff;
	wire cv_fall = ~cv_n & cv_n_ff;
	wire m0_chg = m0 ^ m0_ff;
	wire mode_chg = m0_chg | (m1 ^ m1_ff);
	wire mode_direct = ~m1 & ~m0;
	wire mode_scan = ~m1 & m0;
	wire mode_prog = m1 & ~m0;
	wire mode_run = m1 & m0;
	// input latch: follows pins while write low, frozen while high
	reg [5:0] lat_ff;
	wire [5:0] cfg_now = wr_n ? lat_ff : {dif, ain, pol, gain};
	always @(posedge CLK_I) begin
		if (RST_I) begin
			lat_ff <= 6'h00;
		end else if (!wr_n) begin
			lat_ff <= {dif, ain, pol, gain};
		end
	end
	// sequencer memory: six config bits plus last flag
	reg [5:0] mem [0:`SEQ_DEPTH-1];
	reg [`SEQ_DEPTH-1:0] last_ff;
	reg [3:0] ptr_ff;
	reg [2:0] scan_ff;
	reg [1:0] st_ff;
	reg [CW-1:0] cnt_ff;
	reg [5:0] used_ff;
	reg prev_last_ff;
	wire in_prog = mode_prog & wr_n & ~wr_n_ff;
	always @(posedge CLK_I) begin
		if (mode_prog && wr_rise) begin
			mem[ptr_ff] <= lat_ff;
		end
	end
	always @(posedge CLK_I) begin
		if (RST_I) begin
			last_ff <= {`SEQ_DEPTH{1'b0}};
		end else if (mode_prog && wr_rise) begin
			// newest write marks the end; a restart at zero clears older flags
			last_ff <= (ptr_ff == 4'h0 ? {`SEQ_DEPTH{1'b0}} :
				last_ff & ~({{(`SEQ_DEPTH-1){1'b0}}, 1'b1} << (ptr_ff - 4'h1)))
				| ({{(`SEQ_DEPTH-1){1'b0}}, 1'b1} << ptr_ff);
		end
	end
	wire conv_ok = ~cs_n & ~mode_prog;
	wire start = cv_fall & conv_ok & (st_ff == ST_IDLE);
	wire dif_now = cfg_now[`LOC_DIFFERENTIAL_SELECT];
	// address and config that the starting conversion will use
	reg [5:0] pick;
	always @* begin
		pick = cfg_now;
		if (mode_scan) begin
			pick = {dif_now, scan_ff, cfg_now[1:0]};
		end else if (mode_run) begin
			pick = mem[ptr_ff];
		end
	end
	always @(posedge CLK_I) begin
		if (RST_I) begin
			ptr_ff <= 4'h0;
			scan_ff <= 3'h0;
		end else if (mode_chg) begin
			ptr_ff <= 4'h0;
			if (m0_chg) begin
				scan_ff <= 3'h0;
			end
		end else if (mode_prog && (wr_rise || rd_rise)) begin
			ptr_ff <= ptr_ff + 4'h1;
		end else if (start && mode_run) begin
			ptr_ff <= last_ff[ptr_ff] ? 4'h0 : ptr_ff + 4'h1;
		end else if (start && mode_scan) begin
			// pair mode steps by two and keeps the pair aligned
			scan_ff <= dif_now ? {scan_ff[2:1] + 2'h1, 1'b0} :
				scan_ff + 3'h1;
		end
	end
	// readback word: flag, address, polarity, gain, last flag
	wire [6:0] status = {mem[ptr_ff][5:2], mem[ptr_ff][1:0], last_ff[ptr_ff]};
	wire rd_on = ~cs_n & ~rd_n;
	wire rb_on = mode_prog & rd_on & wr_n;
	// conversion timer stands in for the self-timed internal clock
	always @(posedge CLK_I) begin
		if (RST_I) begin
			st_ff <= ST_IDLE;
			cnt_ff <= {CW{1'b0}};
			used_ff <= 6'h00;
			MUX_SEL_O <= 3'h0;
			MUX_DIFFERENTIAL_SELECT_O <= 1'b0;
			GAIN_O <= 1'b0;
			POLARITY_O <= 1'b0;
			DATA_O <= {RES_W{1'b0}};
			MUX_ADDR_OUT_O <= 3'h0;
			DIFFERENTIAL_FLAG_OUT_O <= 1'b0;
		end else begin
			case (st_ff)
			ST_IDLE: begin
				if (start) begin
					st_ff <= ST_CONV;
					cnt_ff <= CONV_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
					used_ff <= pick;
					{MUX_DIFFERENTIAL_SELECT_O, MUX_SEL_O, POLARITY_O, GAIN_O} <= pick;
				end else if (!mode_scan && !mode_run) begin
					{MUX_DIFFERENTIAL_SELECT_O, MUX_SEL_O, POLARITY_O, GAIN_O} <= cfg_now;
				end
				if (rb_on) begin
					// readback borrows the result pins; the next result refills them
					DATA_O[RES_W-1:RES_W-3] <= status[2:0];
					{DIFFERENTIAL_FLAG_OUT_O, MUX_ADDR_OUT_O} <= status[6:3];
				end
			end
			ST_CONV: begin
				if (cnt_ff != {CW{1'b0}}) begin
					cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
				end else begin
					st_ff <= ST_DONE;
				end
			end
			ST_DONE: begin
				// old result stays on the pins until here
				DATA_O <= RESULT_I;
				MUX_ADDR_OUT_O <= used_ff[4:2];
				DIFFERENTIAL_FLAG_OUT_O <= used_ff[5];
				st_ff <= ST_IDLE;
			end
			default: begin
				st_ff <= ST_IDLE;
			end
			endcase
		end
	end
	assign SAMPLE_O = start;
	assign BUSY_N_O = ~(mode_prog | (st_ff != ST_IDLE));
	// readback drives only the top three data bits plus the address pins
	assign DATA_OE_O = rb_on ? {3'h7, {(RES_W-3){1'b0}}} :
		(mode_prog ? {RES_W{1'b0}} : {RES_W{rd_on}});
	assign ADDR_OE_O = rd_on;
	wire unused = rdy ^ in_prog ^ pin_s[1] ^ pin_s[0];
endmodule // adc_mux_sequencer_control
`default_nettype wire

// file: hdl/adc_seq_defines.vh
// Purpose: constants for the converter control block
// Assumes: 20 MHz system clock
// Notes: counts are in system clock cycles
//
// Contract
// - chip select and read low: start edge converts, data always driven, capture on busy rise
// - with chip select low, data is high impedance until read strobe is low
// - tied read and start: busy drops, old result shown until completion
// - each combined low pulse starts conversion and returns previous result
// - both mode selects low selects direct address mode
// - address/config transparent while write low, held from write rise
// - upper mode low and lower mode high selects scan mode
// - scan ignores address inputs; config bits still latch like direct mode
// - scan single-ended steps eight channels then wraps
// - scan differential steps four pairs from pair 0-1 then repeats
// - differential select honoured per conversion at its current value
// - scan counter clears on any change of lower mode select
// - scan counter advances one single-ended, two differential, per conversion
// - address used, with differential flag, output with the result
// - sequencer holds 16 locations of six bits plus last flag
// - location readable as seven-bit status word on data pins; code puts three bits on the top data pins, four on the address and flag pins
// - upper high, lower low: program/readback access, busy low, no conversions
// - sequencer pointer returns to zero on any mode select change
// - start only with chip select low; busy low whole conversion; no restart
// - program: write rise stores, advances, marks last; wraps after 16
// - readback: read low drives status on upper pins, rise advances, wraps
// - run: conversion uses current location, advances, wraps after last flag
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
`define CLK_HZ 20000000
`define CONV_TIME_NS 1400
`define CONV_CYCLES ((`CONV_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define SEQ_DEPTH 16
`define RES_BITS 12
`define LOC_DIFFERENTIAL_SELECT 5
`define LOC_A2 4
`define LOC_A0 2
`define LOC_POL 1
`define LOC_GAIN 0
`endif

// file: dv/adc_seq_checker_assertions.sv
// Purpose: port checks of the converter control block
// Assumes: chip select is steady around each start
// Notes: bound into the design at the foot
`timescale 1ns/1ns
`default_nettype none
module adc_seq_checker #(parameter RES_W = 12) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CS_N_I,
	input wire logic RD_N_I,
	input wire logic MODE_SELECT_UPPER_I,
	input wire logic MODE_SELECT_LOWER_I,
	input wire logic BUSY_N_O,
	input wire logic SAMPLE_O,
	input wire logic [RES_W-1:0] DATA_O,
	input wire logic [RES_W-1:0] DATA_OE_O,
	input wire logic [2:0] MUX_ADDR_OUT_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	property p_busy_start; SAMPLE_O |=> !BUSY_N_O[*4]; endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy short");
	property p_busy_end;
		$fell(BUSY_N_O) && !MODE_SELECT_UPPER_I |-> ##[1:40] BUSY_N_O;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy stuck");
	property p_no_restart; !BUSY_N_O |-> !SAMPLE_O; endproperty
	a_no_restart: assert property (p_no_restart) else $error("restart");
	property p_cs_gate; SAMPLE_O |-> !$past(CS_N_I, 2); endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("start unselected");
	property p_prog_busy;
		(MODE_SELECT_UPPER_I && !MODE_SELECT_LOWER_I)[*4] |-> !BUSY_N_O && !SAMPLE_O;
	endproperty
	a_prog_busy: assert property (p_prog_busy) else $error("program busy");
	property p_hold;
		BUSY_N_O && $past(BUSY_N_O) |-> $stable(DATA_O) && $stable(MUX_ADDR_OUT_O);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	property p_oe_off; (!CS_N_I && RD_N_I)[*4] |-> DATA_OE_O == '0; endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven");
	property p_oe_on;
		(!CS_N_I && !RD_N_I && !MODE_SELECT_UPPER_I)[*4] |-> &DATA_OE_O;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus not driven");
endmodule // adc_seq_checker
bind adc_mux_sequencer_control adc_seq_checker #(.RES_W(RES_W)) u_chk (
	.CLK_I(CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I), .RD_N_I(RD_N_I),
	.MODE_SELECT_UPPER_I(MODE_SELECT_UPPER_I),
	.MODE_SELECT_LOWER_I(MODE_SELECT_LOWER_I), .BUSY_N_O(BUSY_N_O),
	.SAMPLE_O(SAMPLE_O), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
	.MUX_ADDR_OUT_O(MUX_ADDR_OUT_O));
`default_nettype wire

// file: dv/adc_core_model.sv
// Purpose: converter core answering each sample
// Assumes: result word tags the channel it came from
// Notes: held until the next sample, as a real core would
`timescale 1ns/1ns
`default_nettype none
module adc_core_model (
	input wire logic clk_i,
	input wire logic sample_i,
	input wire logic [2:0] sel_i,
	input wire logic differential_select_i,
	output logic [11:0] result_o
);
	logic sample_d = 1'b0;
	// mux outputs settle on the start edge, so sample one edge later
	always @(posedge clk_i) begin
		sample_d <= sample_i;
		if (sample_d) result_o <= {8'ha5, differential_select_i, sel_i};
	end
endmodule // adc_core_model
`default_nettype wire

// file: dv/tb.sv
// Purpose: directed tests of the converter control block
// Assumes: inputs change on the falling clock edge
// Notes: short conversion count keeps the run brief
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk = 0, rst = 1, cs_n = 0, rd_n = 1, wr_n = 0, cnv = 1;
	logic mu = 0, ml = 0, dsel = 0, gain = 0, pol = 0;
	logic [2:0] ain = 0, msel, aout;
	logic [11:0] res, dat, oe;
	logic busy_n, smp, mdiff, dfo, aoe, gout, pout;
	integer fail_count = 0, comparisons = 0, i;
	always #25 clk = ~clk;
	adc_core_model u_core (.clk_i(clk), .sample_i(smp), .sel_i(msel),
		.differential_select_i(mdiff), .result_o(res));
	adc_mux_sequencer_control #(.CONV_CYC(4)) u_dut (.CLK_I(clk), .RST_I(rst),
		.CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n), .CONVERSION_START_N_I(cnv),
		.MODE_SELECT_UPPER_I(mu), .MODE_SELECT_LOWER_I(ml),
		.DIFFERENTIAL_SELECT_I(dsel), .GAIN_RANGE_SELECT_I(gain),
		.POLARITY_SELECT_I(pol), .MUX_ADDR_IN_I(ain), .RESULT_I(res),
		.RESULT_READY_I(1'b0), .BUSY_N_O(busy_n), .SAMPLE_O(smp),
		.MUX_SEL_O(msel), .MUX_DIFFERENTIAL_SELECT_O(mdiff), .GAIN_O(gout),
		.POLARITY_O(pout),
		.DATA_O(dat), .DATA_OE_O(oe), .MUX_ADDR_OUT_O(aout),
		.DIFFERENTIAL_FLAG_OUT_O(dfo), .ADDR_OE_O(aoe));
	task chk(input ok);
		comparisons = comparisons + 1;
		if (!ok) begin
			fail_count = fail_count + 1;
			$display("BAD %0t mismatch", $time);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	// host waits on busy before reading, as a slow-memory host would
	task cv(input [2:0] a, input d);
		integer n;
		cnv = 0;
		for (n = 0; n < 20 && busy_n !== 1'b0; n = n + 1) cyc(1);
		cnv = 1;
		for (n = 0; n < 40 && busy_n !== 1'b1; n = n + 1) cyc(1);
		chk({aout, dfo, dat} === {a, d, 8'ha5, d, a});
	endtask
	// every mode change also restarts the pointer before sequencer access
	task md(input u, input l);
		mu = u;
		ml = l;
		cyc(5);
	endtask
	task wr(input [2:0] a, input d);
		ain = a;
		dsel = d;
		wr_n = 0;
		cyc(4);
		wr_n = 1;
		cyc(4);
	endtask
	task end_of_test;
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#3000000;
		fail_count = fail_count + 1;
		end_of_test;
	end
	initial begin
		cyc(2);
		rst = 0;
		rd_n = 0;
		wr(3'h5, 1);
		ain = 3'h2;
		dsel = 0;
		cv(3'h5, 1);
		chk(oe === 12'hfff);
		wr_n = 0;
		gain = 1;
		pol = 1;
		cv(3'h2, 0);
		chk({gout, pout} === 2'b11);
		gain = 0;
		pol = 0;
		rd_n = 1;
		cyc(5);
		chk(oe === 12'h000);
		cs_n = 1;
		cnv = 0;
		cyc(10);
		chk(busy_n === 1'b1);
		cnv = 1;
		cs_n = 0;
		ain = 3'h7;
		md(0, 1);
		for (i = 0; i < 9; i = i + 1) cv(i[2:0], 0);
		md(0, 0);
		md(0, 1);
		dsel = 1;
		for (i = 0; i < 5; i = i + 1) cv(3'(2 * i), 1);
		md(0, 0);
		md(0, 1);
		for (i = 0; i < 6; i = i + 1) begin
			dsel = (i == 2 || i == 5);
			cv(3'(i + i / 3), dsel);
		end
		wr_n = 1;
		md(1, 0);
		chk(busy_n === 1'b0);
		wr(3'h3, 0);
		wr(3'h6, 1);
		wr(3'h1, 0);
		md(1, 1);
		md(1, 0);
		rd_n = 0;
		cyc(5);
		chk(oe[8:0] === 9'h000 && aoe === 1'b1);
		chk({dfo, aout, dat[11:9]} === 7'b0011000);
		rd_n = 1;
		cyc(3);
		rd_n = 0;
		cyc(3);
		rd_n = 1;
		cyc(3);
		rd_n = 0;
		cyc(5);
		chk({dfo, aout, dat[11:9]} === 7'b0001001);
		rd_n = 1;
		md(1, 1);
		dsel = 1;
		cv(3'h3, 0);
		cv(3'h6, 1);
		cv(3'h1, 0);
		cv(3'h3, 0);
		end_of_test;
	end
endmodule // tb
`default_nettype wire
